// >>> hctc_channel_ctrl.sv
// Host channel transaction controller with its Avalon-MM register slave and link token port.
// Overview of operation
// - Clean transaction reports code 000.
// - STALL handshake reports code 001.
// - Too long packet or total reports 010.
// - CRC plus stuffing error is retry 100.
// - Short packet, wrong toggle: retry, not excess.
// - Short packet below remaining count reports 011.
// - Timeout, CRC, stuffing, PID, toggle errors retry.
// - ACK counter flags target; zero means sixteen.
// - Assist counts only data transport ACKs.
// - Speed 00 high, 01 full; never others. The field takes 10 and 11 as written and drives them out.
// - Toggle bit seeds and tracks data toggle.
// - Run bit starts, stops, shows activity.
// - Full count done sets flag, clears run.
// - Halt event clears run, keeps result code.
// - Stop finishes current transaction, then halts.
// - Stop keeps counts and settings; resume continues.
// - Direction 01 issues OUT, 10 IN.
// - Assist-started transfers ignore direction field.
// - Auto terminator adds OUT zero-length packet.
// - Unlimited mode ignores the byte count limit.
// - Count drops per good transaction; zero sends ZLP.
//
// Local design decision: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module hctc_channel_ctrl
  import hctc_pkg::*;
(
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_in,
  // Avalon-MM register slave
  input wire logic [11:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // Token request toward the link
  output logic tok_req_out,
  output logic tok_is_in_out,
  output logic tok_toggle_out,
  output logic [1:0] tok_speed_out,
  output logic [9:0] tok_len_out,
  // Transaction outcome from the link
  input wire logic lnk_done_in,
  input wire logic lnk_ack_in,
  input wire logic lnk_stall_in,
  input wire logic lnk_timeout_in,
  input wire logic lnk_crc_err_in,
  input wire logic lnk_stuff_err_in,
  input wire logic lnk_pid_err_in,
  input wire logic lnk_rx_toggle_in,
  input wire logic [10:0] lnk_rx_len_in,
  // Mass-storage assist status
  input wire logic msa_run_in,
  input wire logic msa_started_in,
  input wire logic msa_is_in_in,
  input wire logic msa_data_phase_in
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    hctc_state_e st;
    logic run;
    logic stop_pend;
    logic toggle;
    logic [3:0] ack_tgt;
    logic [1:0] speed;
    logic [1:0] token_direction_select;
    logic azl;
    logic ulim;
    logic [9:0] pkt_limit;
    logic [31:0] remain;
    logic [4:0] ack_cnt;
    logic [2:0] code;
    logic [2:0] ev;
    logic cur_in;
    logic by_msa;
    logic wait_n;
    logic [31:0] rdata;
    logic tok_req;
    logic [9:0] tok_len;
  } hctc_state_s;

  hctc_state_s s_r;
  hctc_state_s s_nxt;
  logic [2:0] res_code;
  logic normal_end;
  logic [4:0] ack_target;

  // Merge a 32-bit write into a register under its byte enables.
  function automatic logic [31:0] be_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction : be_merge

  // Packet limit in unlimited mode, else the smaller of it and the remaining count, as the next OUT length.
  function automatic logic [9:0] next_len(input logic [31:0] remain, input logic [9:0] lim, input logic ulim);
    if (ulim || (remain >= {22'h000000, lim})) begin
      return lim;
    end
    return remain[9:0];
  endfunction : next_len

  // Outcome classification of the transaction in flight.
  hctc_result_classifier u_classify (
    .is_in_in(s_r.cur_in),
    .exp_toggle_in(s_r.toggle),
    .pkt_limit_in(s_r.pkt_limit),
    .remain_in(s_r.remain),
    .unlimited_in(s_r.ulim),
    .ack_in(lnk_ack_in),
    .stall_in(lnk_stall_in),
    .timeout_in(lnk_timeout_in),
    .crc_err_in(lnk_crc_err_in),
    .stuff_err_in(lnk_stuff_err_in),
    .pid_err_in(lnk_pid_err_in),
    .rx_toggle_in(lnk_rx_toggle_in),
    .rx_len_in(lnk_rx_len_in),
    .code_out(res_code)
  );

  // A zero target stands for sixteen ACKs.
  assign ack_target = (s_r.ack_tgt == 4'h0) ? ACK_TARGET_ZERO : {1'b0, s_r.ack_tgt};
  assign normal_end = (s_r.st == HCTC_WAIT) && lnk_done_in && (res_code == CODE_NO_ERROR);

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  // Bus access first, then the sequencer; hardware-set event bits win over a same-cycle clear.
  always_comb begin
    logic [2:0] ev_set;
    logic [2:0] ev_clr;
    logic [9:0] idx;
    logic [31:0] rd;
    logic [31:0] done_len;
    logic [31:0] left;
    logic [31:0] lim_merge;
    ev_set = 3'h0;
    ev_clr = 3'h0;
    idx = avs_address_in[11:2];
    rd = 32'h0000_0000;
    done_len = 32'h0000_0000;
    left = 32'h0000_0000;
    lim_merge = be_merge({22'h000000, s_r.pkt_limit}, avs_writedata_in, avs_byteenable_in);
    s_nxt = s_r;
    s_nxt.tok_req = 1'b0;
    s_nxt.wait_n = 1'b0;
    // Register read mux; unmapped words read as zero and are still answered.
    if (idx == IDX_CH0_RESULT) begin
      rd = {24'h000000, 1'b0, s_r.code, 4'h0};
    end else if (idx == IDX_CFG_PRI) begin
      rd = {24'h000000, s_r.ack_tgt, s_r.speed, s_r.toggle, s_r.run};
    end else if (idx == IDX_CFG_SEC) begin
      rd = {24'h000000, s_r.token_direction_select, 2'h0, s_r.azl, 2'h0, s_r.ulim};
    end else if (idx == IDX_PKT_LIMIT) begin
      rd = {22'h000000, s_r.pkt_limit};
    end else if (idx == IDX_BYTE_COUNT) begin
      rd = s_r.remain;
    end else if (idx == IDX_EVENT_STAT) begin
      rd = {29'h00000000, s_r.ev};
    end
    // One wait cycle, then the answer; writes take effect on the answering edge.
    if ((avs_read_in || avs_write_in) && !s_r.wait_n) begin
      s_nxt.wait_n = 1'b1;
      s_nxt.rdata = rd;
    end
    if (avs_write_in && s_r.wait_n && avs_byteenable_in[0]) begin
      if (idx == IDX_CFG_PRI) begin
        s_nxt.ack_tgt = avs_writedata_in[CFG_ACK_LSB +: 4];
        s_nxt.speed = avs_writedata_in[CFG_SPEED_LSB +: 2];
        s_nxt.toggle = avs_writedata_in[CFG_TOGGLE_BIT];
        if (avs_writedata_in[CFG_RUN_BIT]) begin
          s_nxt.run = 1'b1;
          s_nxt.stop_pend = 1'b0;
        end else if (s_r.st != HCTC_IDLE) begin
          s_nxt.stop_pend = 1'b1;
        end else begin
          s_nxt.run = 1'b0;
        end
      end else if (idx == IDX_CFG_SEC) begin
        s_nxt.token_direction_select = avs_writedata_in[CFG2_TID_LSB +: 2];
        s_nxt.azl = avs_writedata_in[CFG2_AZL_BIT];
        s_nxt.ulim = avs_writedata_in[CFG2_ULIM_BIT];
      end else if (idx == IDX_EVENT_STAT) begin
        ev_clr = avs_writedata_in[2:0];
      end
    end
    if (avs_write_in && s_r.wait_n) begin
      if (idx == IDX_PKT_LIMIT) begin
        s_nxt.pkt_limit = lim_merge[9:0];
      end else if (idx == IDX_BYTE_COUNT) begin
        s_nxt.remain = be_merge(s_r.remain, avs_writedata_in, avs_byteenable_in);
      end
    end
    // Channel sequencer.
    case (s_r.st)
      HCTC_IDLE: begin
        if (s_r.run && !s_r.stop_pend) begin
          s_nxt.st = HCTC_ISSUE;
        end
      end
      HCTC_ISSUE: begin
        // Assist-started transfers take their direction from the assist, not the field.
        s_nxt.by_msa = msa_run_in && msa_started_in;
        s_nxt.cur_in = (msa_run_in && msa_started_in) ? msa_is_in_in : (s_r.token_direction_select == TID_IN);
        // A zero remaining count yields a zero-length OUT packet.
        s_nxt.tok_len = next_len(s_r.remain, s_r.pkt_limit, s_r.ulim);
        s_nxt.tok_req = 1'b1;
        s_nxt.st = HCTC_WAIT;
      end
      HCTC_WAIT: begin
        if (lnk_done_in) begin
          s_nxt.code = res_code;
          s_nxt.st = HCTC_IDLE;
          if (res_code == CODE_NO_ERROR) begin
            done_len = s_r.cur_in ? {21'h000000, lnk_rx_len_in} : {22'h000000, s_r.tok_len};
            left = s_r.ulim ? s_r.remain : (s_r.remain - done_len);
            s_nxt.remain = left;
            s_nxt.toggle = !s_r.toggle;
            // During assist operation only data transport phases count.
            if (!s_r.by_msa || msa_data_phase_in) begin
              if ((s_r.ack_cnt + 5'h01) == ack_target) begin
                ev_set[EV_ACK_BIT] = 1'b1;
                s_nxt.ack_cnt = 5'h00;
              end else begin
                s_nxt.ack_cnt = s_r.ack_cnt + 5'h01;
              end
            end
            // The terminating zero-length packet is sent only after a full-size final OUT packet.
            if (!s_r.ulim && (left == 32'h0000_0000) &&
                !(s_r.azl && !s_r.cur_in && (s_r.tok_len == s_r.pkt_limit) && (s_r.tok_len != 10'h000))) begin
              ev_set[EV_SIZE_BIT] = 1'b1;
              s_nxt.run = 1'b0;
              s_nxt.stop_pend = 1'b0;
            end else if (s_r.stop_pend) begin
              ev_set[EV_HALT_BIT] = 1'b1;
              s_nxt.run = 1'b0;
              s_nxt.stop_pend = 1'b0;
            end
          end else begin
            ev_set[EV_HALT_BIT] = 1'b1;
            s_nxt.run = 1'b0;
            s_nxt.stop_pend = 1'b0;
          end
        end
      end
      default: begin
        s_nxt.st = HCTC_IDLE;
      end
    endcase
    s_nxt.ev = (s_r.ev & ~ev_clr) | ev_set;
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  // Synchronous reset leaves the channel stopped with every setting at its reset value.
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      s_r <= '0;
      s_r.st <= HCTC_IDLE;
      s_r.ack_tgt <= CFG_PRI_RST[CFG_ACK_LSB +: 4];
      s_r.speed <= CFG_PRI_RST[CFG_SPEED_LSB +: 2];
      s_r.toggle <= CFG_PRI_RST[CFG_TOGGLE_BIT];
      s_r.run <= CFG_PRI_RST[CFG_RUN_BIT];
      s_r.token_direction_select <= CFG_SEC_RST[CFG2_TID_LSB +: 2];
      s_r.azl <= CFG_SEC_RST[CFG2_AZL_BIT];
      s_r.ulim <= CFG_SEC_RST[CFG2_ULIM_BIT];
      s_r.pkt_limit <= PKT_LIMIT_RST;
      s_r.remain <= BYTE_COUNT_RST;
      s_r.code <= CODE_NO_ERROR;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Every output is a flip-flop of the state, except waitrequest, which is the inverse of wait_n.
  assign avs_readdata_out = s_r.rdata;
  assign avs_waitrequest_out = !s_r.wait_n;
  assign tok_req_out = s_r.tok_req;
  assign tok_is_in_out = s_r.cur_in;
  assign tok_toggle_out = s_r.toggle;
  assign tok_speed_out = s_r.speed;
  assign tok_len_out = s_r.tok_len;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  property p_code_legal;
    @(posedge mclk_in) disable iff (rst_in) s_r.code <= CODE_RETRY_FAIL;
  endproperty
  a_code_legal: assert property (p_code_legal) else $error("reserved result code");

  property p_stall_code;
    @(posedge mclk_in) disable iff (rst_in)
      (s_r.st == HCTC_WAIT && lnk_done_in && lnk_stall_in && !lnk_crc_err_in && !lnk_stuff_err_in &&
       !lnk_timeout_in && !lnk_pid_err_in) |=> (s_r.code == CODE_STALL) && !s_r.run;
  endproperty
  a_stall_code: assert property (p_stall_code) else $error("stall not reported");

  property p_dual_err;
    @(posedge mclk_in) disable iff (rst_in)
      (s_r.st == HCTC_WAIT && lnk_done_in && lnk_crc_err_in && lnk_stuff_err_in) |=> s_r.code == CODE_RETRY_FAIL;
  endproperty
  a_dual_err: assert property (p_dual_err) else $error("dual error not retry");

  property p_toggle_flip;
    @(posedge mclk_in) disable iff (rst_in) normal_end |=> s_r.toggle != $past(s_r.toggle);
  endproperty
  a_toggle_flip: assert property (p_toggle_flip) else $error("toggle not advanced");

  property p_ack_target;
    @(posedge mclk_in) disable iff (rst_in)
      $rose(s_r.ev[EV_ACK_BIT]) |-> ($past(s_r.ack_cnt) + 5'h01) == $past(ack_target) && s_r.ack_cnt == 5'h00;
  endproperty
  a_ack_target: assert property (p_ack_target) else $error("ack flag off target");

  property p_size_done;
    @(posedge mclk_in) disable iff (rst_in)
      $rose(s_r.ev[EV_SIZE_BIT]) |-> !s_r.run && s_r.st == HCTC_IDLE && (s_r.remain == 32'h0000_0000);
  endproperty
  a_size_done: assert property (p_size_done) else $error("size completion wrong");

  property p_halt_run;
    @(posedge mclk_in) disable iff (rst_in) $rose(s_r.ev[EV_HALT_BIT]) |-> !s_r.run ##1 !s_r.tok_req;
  endproperty
  a_halt_run: assert property (p_halt_run) else $error("halt left run set");

  property p_issue_dir;
    @(posedge mclk_in) disable iff (rst_in)
      (s_r.st == HCTC_ISSUE && !(msa_run_in && msa_started_in)) |=>
        tok_req_out && (tok_is_in_out == ($past(s_r.token_direction_select) == TID_IN)) ##1 !tok_req_out;
  endproperty
  a_issue_dir: assert property (p_issue_dir) else $error("token direction wrong");

  property p_stop_finish;
    @(posedge mclk_in) disable iff (rst_in)
      (s_r.stop_pend && s_r.st == HCTC_WAIT && normal_end && !s_nxt.ev[EV_SIZE_BIT]) |=>
        s_r.ev[EV_HALT_BIT] && !s_r.run && (s_r.code == CODE_NO_ERROR);
  endproperty
  a_stop_finish: assert property (p_stop_finish) else $error("stop did not halt");

endmodule : hctc_channel_ctrl

// >>> hctc_link_model.sv
// Behavioural USB endpoint model that answers the channel's tokens.
`timescale 1ns/1ps
module hctc_link_model (
  // Clock
  input wire logic mclk_in,
  // Token from the channel
  input wire logic tok_req_in,
  input wire logic tok_toggle_in,
  // Behaviour chosen by the bench
  input wire logic [2:0] kind_in,
  input wire logic [7:0] dly_in,
  input wire logic [10:0] len_in,
  input wire logic bad_tgl_in,
  // Outcome toward the channel
  output logic done_out = 1'b0,
  output logic ack_out = 1'b0,
  output logic stall_out = 1'b0,
  output logic timeout_out = 1'b0,
  output logic crc_out = 1'b0,
  output logic stuff_out = 1'b0,
  output logic pid_out = 1'b0,
  output logic tgl_out = 1'b0,
  output logic [10:0] len_out = 11'h000
);
  int cnt = -1;

  // ****************************************************************
  // Responder
  // ****************************************************************
  // Outside the answer cycle done stays low and every other flag flips each cycle, so a channel that samples early sees rubbish.
  always @(posedge mclk_in) begin
    done_out <= 1'b0;
    {ack_out, stall_out, timeout_out, crc_out, stuff_out, pid_out, tgl_out} <=
      ~{ack_out, stall_out, timeout_out, crc_out, stuff_out, pid_out, tgl_out};
    len_out <= ~len_out;
    if (tok_req_in === 1'b1) begin
      cnt = dly_in;
    end else if (cnt > 0) begin
      cnt = cnt - 1;
    end else if (cnt == 0) begin
      cnt = -1;
      done_out <= 1'b1;
      ack_out <= (kind_in == 3'h0);
      stall_out <= (kind_in == 3'h1);
      timeout_out <= (kind_in == 3'h2);
      crc_out <= (kind_in == 3'h3);
      stuff_out <= (kind_in == 3'h3);
      pid_out <= (kind_in == 3'h4);
      tgl_out <= tok_toggle_in ^ bad_tgl_in;
      len_out <= len_in;
    end
  end
endmodule : hctc_link_model

// >>> hctc_pkg.sv
// Package with register map, field layout, result codes and state encoding of the host channel controller.
package hctc_pkg;

  // ****************************************************************
  // Register indices (byte address is four times the index)
  // ****************************************************************
  localparam logic [9:0] IDX_CH0_RESULT = 10'h12e;
  localparam logic [9:0] IDX_CFG_PRI = 10'h130;
  localparam logic [9:0] IDX_CFG_SEC = 10'h131;
  localparam logic [9:0] IDX_PKT_LIMIT = 10'h140;
  localparam logic [9:0] IDX_BYTE_COUNT = 10'h141;
  localparam logic [9:0] IDX_EVENT_STAT = 10'h142;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int CFG_RUN_BIT = 0;
  localparam int CFG_TOGGLE_BIT = 1;
  localparam int CFG_SPEED_LSB = 2;
  localparam int CFG_ACK_LSB = 4;
  localparam int CFG2_ULIM_BIT = 0;
  localparam int CFG2_AZL_BIT = 3;
  localparam int CFG2_TID_LSB = 6;
  localparam int RES_CODE_LSB = 4;
  localparam int EV_ACK_BIT = 0;
  localparam int EV_SIZE_BIT = 1;
  localparam int EV_HALT_BIT = 2;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [7:0] CFG_PRI_RST = 8'h00;
  localparam logic [7:0] CFG_SEC_RST = 8'h00;
  localparam logic [9:0] PKT_LIMIT_RST = 10'h000;
  localparam logic [31:0] BYTE_COUNT_RST = 32'h0000_0000;

  // ****************************************************************
  // Encodings
  // ****************************************************************
  localparam logic [2:0] CODE_NO_ERROR = 3'h0;
  localparam logic [2:0] CODE_STALL = 3'h1;
  localparam logic [2:0] CODE_EXCESS_DATA = 3'h2;
  localparam logic [2:0] CODE_SHORT_DATA = 3'h3;
  localparam logic [2:0] CODE_RETRY_FAIL = 3'h4;
  localparam logic [1:0] TID_OUT = 2'h1;
  localparam logic [1:0] TID_IN = 2'h2;
  localparam logic [1:0] SPEED_HIGH = 2'h0;
  localparam logic [1:0] SPEED_FULL = 2'h1;
  localparam logic [4:0] ACK_TARGET_ZERO = 5'h10;

  // Channel sequencer states, Gray coded along idle, issue, wait.
  typedef enum logic [1:0] {
    HCTC_IDLE = 2'b00,
    HCTC_ISSUE = 2'b01,
    HCTC_WAIT = 2'b11
  } hctc_state_e;

endpackage : hctc_pkg

// >>> hctc_result_classifier.sv
// Combinational classifier that turns a transaction outcome into a completion result code.
`timescale 1ns/1ps
module hctc_result_classifier
  import hctc_pkg::*;
(
  // Transaction context
  input wire logic is_in_in,
  input wire logic exp_toggle_in,
  input wire logic [9:0] pkt_limit_in,
  input wire logic [31:0] remain_in,
  input wire logic unlimited_in,
  // Link outcome
  input wire logic ack_in,
  input wire logic stall_in,
  input wire logic timeout_in,
  input wire logic crc_err_in,
  input wire logic stuff_err_in,
  input wire logic pid_err_in,
  input wire logic rx_toggle_in,
  input wire logic [10:0] rx_len_in,
  // Result
  output logic [2:0] code_out
);

  logic short_pkt;
  logic long_pkt;
  logic over_total;

  // Length comparisons shared by the overrun and underrun decisions.
  assign short_pkt = rx_len_in < {1'b0, pkt_limit_in};
  assign long_pkt = rx_len_in > {1'b0, pkt_limit_in};
  assign over_total = !unlimited_in && ({21'h000000, rx_len_in} > remain_in);

  // ****************************************************************
  // Priority of outcomes
  // ****************************************************************
  // Line errors win over every size outcome, so a combined CRC and stuffing fault never reads as overrun.
  always_comb begin
    code_out = CODE_NO_ERROR;
    if ((crc_err_in && stuff_err_in) || crc_err_in || stuff_err_in || timeout_in || pid_err_in) begin
      code_out = CODE_RETRY_FAIL;
    end else if (stall_in) begin
      code_out = CODE_STALL;
    end else if (!is_in_in) begin
      if (!ack_in) begin
        code_out = CODE_RETRY_FAIL;
      end
    end else if (long_pkt) begin
      code_out = CODE_EXCESS_DATA;
    end else if (rx_toggle_in != exp_toggle_in) begin
      code_out = CODE_RETRY_FAIL;
    end else if (over_total) begin
      code_out = CODE_EXCESS_DATA;
    end else if (short_pkt && ({21'h000000, rx_len_in} < remain_in)) begin
      code_out = CODE_SHORT_DATA;
    end
  end

endmodule : hctc_result_classifier

// >>> tb_top.sv
// Self-checking bench of the host channel controller against an endpoint model.
`timescale 1ns/1ps
module tb_top;
  import hctc_pkg::*;
  logic mclk_in, rst_in = 1'b1, rd = 1'b0, wr = 1'b0, wreq, m_bad = 1'b0;
  logic [11:0] adr = 12'h000;
  logic [31:0] wdat = 32'h0, rdat, v;
  logic tok_req, tok_is_in, tok_toggle, done, ack, stall, tmo, crc, stuff, pid, rtgl;
  logic [1:0] tok_speed;
  logic [9:0] tok_len;
  logic [10:0] rlen, m_len = 11'h000;
  logic [2:0] m_kind = 3'h0;
  logic m_msa = 1'b0, m_dph = 1'b0;
  logic [7:0] m_dly = 8'h02;
  logic [9:0] lens[$];
  int mismatches = 0;
  int samples_checked = 0;
  int tk[9] = '{1, 2, 3, 4, 0, 0, 0, 0, 0};
  int tl[9] = '{10, 10, 70, 10, 70, 10, 10, 50, 64};
  int tb[9] = '{0, 0, 0, 0, 0, 0, 1, 0, 0};
  int tc[9] = '{100, 100, 100, 100, 100, 100, 100, 40, 64};
  int te[9] = '{1, 4, 4, 4, 2, 3, 4, 2, 0};

  hctc_channel_ctrl u_hctc_channel_ctrl (.mclk_in(mclk_in), .rst_in(rst_in), .avs_address_in(adr),
    .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdat), .avs_byteenable_in(4'hf),
    .avs_readdata_out(rdat), .avs_waitrequest_out(wreq), .tok_req_out(tok_req), .tok_is_in_out(tok_is_in),
    .tok_toggle_out(tok_toggle), .tok_speed_out(tok_speed), .tok_len_out(tok_len), .lnk_done_in(done),
    .lnk_ack_in(ack), .lnk_stall_in(stall), .lnk_timeout_in(tmo), .lnk_crc_err_in(crc),
    .lnk_stuff_err_in(stuff), .lnk_pid_err_in(pid), .lnk_rx_toggle_in(rtgl), .lnk_rx_len_in(rlen),
    .msa_run_in(m_msa), .msa_started_in(m_msa), .msa_is_in_in(m_msa), .msa_data_phase_in(m_dph));
  hctc_link_model u_hctc_link_model (.mclk_in(mclk_in), .tok_req_in(tok_req), .tok_toggle_in(tok_toggle),
    .kind_in(m_kind), .dly_in(m_dly), .len_in(m_len), .bad_tgl_in(m_bad), .done_out(done), .ack_out(ack),
    .stall_out(stall), .timeout_out(tmo), .crc_out(crc), .stuff_out(stuff), .pid_out(pid),
    .tgl_out(rtgl), .len_out(rlen));

  // ****************************************************************
  // Clock, token log and watchdog
  // ****************************************************************
  // Free running system clock.
  initial begin
    mclk_in = 1'b0;
    forever #10 mclk_in = ~mclk_in;
  end
  // Every issued token length is logged for later comparison.
  always @(posedge mclk_in) if (tok_req === 1'b1) lens.push_back(tok_len);
  // The whole sequence needs well under a tenth of this span.
  initial begin
    repeat (60000) @(posedge mclk_in);
    mismatches++;
    end_of_test();
  end

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic end_of_test();
    $display("checked %0d, mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_of_test
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // One Avalon cycle; the leading edge keeps back-to-back calls from colliding in one time step.
  task automatic bus(input logic w, input logic [9:0] idx, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge mclk_in);
    adr <= {idx, 2'b00};
    wdat <= d;
    rd <= ~w;
    wr <= w;
    do begin
      @(posedge mclk_in);
      n++;
    end while (wreq !== 1'b0 && n < 100);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    if (n >= 100) mismatches++;
  endtask : bus
  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      bus(1'b0, IDX_CFG_PRI, 32'h0, v);
      n++;
    end while (v[CFG_RUN_BIT] !== 1'b0 && n < 300);
    if (n >= 300) mismatches++;
  endtask : wait_idle
  task automatic start(input logic [9:0] lim, input logic [31:0] cnt, input logic [7:0] sec, input logic [7:0] pri);
    lens.delete();
    bus(1'b1, IDX_EVENT_STAT, 32'h7, v);
    bus(1'b1, IDX_PKT_LIMIT, {22'h0, lim}, v);
    bus(1'b1, IDX_BYTE_COUNT, cnt, v);
    bus(1'b1, IDX_CFG_SEC, {24'h0, sec}, v);
    bus(1'b1, IDX_CFG_PRI, {24'h0, pri}, v);
  endtask : start
  // Expected tokens: full packets, the remainder, and a trailing empty one when asked for.
  task automatic chk_lens(input int lim, input int cnt, input bit azl);
    int rem, k, last;
    rem = cnt;
    k = 0;
    do begin
      last = (rem < lim) ? rem : lim;
      chk("tok_len", last, {22'h0, lens[k]});
      rem -= last;
      k++;
    end while (rem > 0);
    if (azl && last == lim) begin
      chk("tok_len", 0, {22'h0, lens[k]});
      k++;
    end
    chk("tok_total", k, lens.size());
  endtask : chk_lens
  task automatic rd_chk(input string nm, input logic [9:0] idx, input logic [31:0] e);
    bus(1'b0, idx, 32'h0, v);
    chk(nm, e, v);
  endtask : rd_chk

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    repeat (20) @(posedge mclk_in);
    rst_in <= 1'b0;
    @(posedge mclk_in);
    rd_chk("cfg_pri", IDX_CFG_PRI, {24'h0, CFG_PRI_RST});
    rd_chk("cfg_sec", IDX_CFG_SEC, {24'h0, CFG_SEC_RST});
    rd_chk("result", IDX_CH0_RESULT, 32'h0);
    bus(1'b1, 10'h3ff, 32'hff, v);
    rd_chk("unmapped", 10'h3ff, 32'h0);
    $display("test reset done");
    start(10'd64, 32'd100, 8'h40, 8'h25);
    wait_idle();
    chk_lens(64, 100, 0);
    rd_chk("event", IDX_EVENT_STAT, 32'h3);
    rd_chk("count", IDX_BYTE_COUNT, 32'h0);
    rd_chk("cfg_pri", IDX_CFG_PRI, 32'h24);
    chk("speed", SPEED_FULL, {30'h0, tok_speed});
    chk("is_in", 0, {31'h0, tok_is_in});
    start(10'd8, 32'd0, 8'h40, 8'h15);
    wait_idle();
    chk_lens(8, 0, 0);
    rd_chk("event", IDX_EVENT_STAT, 32'h3);
    $display("test out done");
    for (int i = 0; i < 2; i++) begin
      start(10'd8, 32'd128 - 32'(i * 8), 8'h40, 8'h05);
      wait_idle();
      rd_chk("event", IDX_EVENT_STAT, (i == 0) ? 32'h3 : 32'h2);
    end
    // The counter stands at fifteen here; only a data phase may carry it to the target.
    m_msa <= 1'b1;
    m_len <= 11'd10;
    for (int i = 0; i < 2; i++) begin
      m_dph <= 1'(i);
      start(10'd64, 32'd10, 8'h40, 8'h05);
      wait_idle();
      chk("is_in", 1, {31'h0, tok_is_in});
      rd_chk("event", IDX_EVENT_STAT, 32'h2 + 32'(i));
    end
    m_msa <= 1'b0;
    $display("test ack count done");
    start(10'd64, 32'd128, 8'h48, 8'h01);
    wait_idle();
    chk_lens(64, 128, 1);
    rd_chk("cfg_pri", IDX_CFG_PRI, 32'h02);
    chk("speed", SPEED_HIGH, {30'h0, tok_speed});
    $display("test terminator done");
    for (int i = 0; i < 9; i++) begin
      m_kind <= 3'(tk[i]);
      m_len <= 11'(tl[i]);
      m_bad <= 1'(tb[i]);
      start(10'd64, 32'(tc[i]), 8'h88, 8'h03);
      wait_idle();
      chk("tok_toggle", (te[i] == 0) ? 0 : 1, {31'h0, tok_toggle});
      chk("is_in", 1, {31'h0, tok_is_in});
      rd_chk("result", IDX_CH0_RESULT, 32'(te[i]) << RES_CODE_LSB);
      bus(1'b0, IDX_EVENT_STAT, 32'h0, v);
      chk("event", (te[i] == 0) ? 32'h2 : 32'h4, v & 32'h6);
      rd_chk("count", IDX_BYTE_COUNT, (te[i] == 0) ? 32'h0 : 32'(tc[i]));
    end
    m_kind <= 3'h0;
    m_bad <= 1'b0;
    $display("test in results done");
    m_dly <= 8'd30;
    start(10'd64, 32'd192, 8'h40, 8'h01);
    bus(1'b1, IDX_CFG_PRI, 32'h0, v);
    rd_chk("cfg_pri", IDX_CFG_PRI, 32'h01);
    wait_idle();
    rd_chk("event", IDX_EVENT_STAT, 32'h4);
    rd_chk("count", IDX_BYTE_COUNT, 32'd128);
    rd_chk("limit", IDX_PKT_LIMIT, 32'd64);
    rd_chk("cfg_sec", IDX_CFG_SEC, 32'h40);
    bus(1'b0, IDX_CFG_PRI, 32'h0, v);
    bus(1'b1, IDX_CFG_PRI, v | 32'h1, v);
    wait_idle();
    chk_lens(64, 192, 0);
    rd_chk("event", IDX_EVENT_STAT, 32'h6);
    $display("test stop resume done");
    m_dly <= 8'd5;
    start(10'd64, 32'd10, 8'h41, 8'h01);
    for (int n = 0; n < 500 && lens.size() < 2; n++) @(posedge mclk_in);
    bus(1'b1, IDX_CFG_PRI, 32'h0, v);
    wait_idle();
    chk("tok_len", 64, {22'h0, lens[1]});
    rd_chk("count", IDX_BYTE_COUNT, 32'd10);
    $display("test unlimited done");
    end_of_test();
  end
endmodule : tb_top
